// ---- rtl/dram_ctrl.sv ----
// Controller driving a 16K by 4 asynchronous dynamic memory
// How it works
// - Address lines are stable before each column and row strobe fall, except refresh rows, set on the same edge as the row strobe fall.
// - Raise output enable and let outputs float before driving data.
// - Strobe all 256 rows with the row strobe every four milliseconds; the timer restarts after each refresh, so a pass takes over 4 ms.
// - Page mode keeps row open across column strobes, up to 64 columns.
// - After power-up hold row strobe high 100 us, then eight cycles.
`timescale 1ns/100ps
`include "dram_ctrl_params.svh"
module dram_ctrl #(
    parameter int POWERUP_CYCLES = `POWERUP_HOLD_CYCLES,
    parameter int REFRESH_CYCLES = `REFRESH_INT_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // User requests
    input  wire logic                  req_valid,
    input  wire dram_ctrl_pkg::req_type req,
    output logic                       req_ready,
    output logic                       rdata_valid,
    output logic [3:0]                 rdata,
    output logic                       init_done,
    // Memory pins
    output dram_ctrl_pkg::pins_type    pins,
    input  wire logic [3:0]            data_lines_in,
    output logic [3:0]                 data_lines_out,
    output logic                       data_lines_oe_b
);
    typedef enum logic [3:0] {
        st_power, st_init_low, st_init_high, st_idle, st_row,
        st_col, st_read_wait, st_rmw_float, st_rmw_write,
        st_col_end, st_precharge, st_ref_low
    } state_type;

    state_type   state;
    logic [15:0] count;
    logic [3:0]  init_left;
    logic [23:0] ref_timer;
    logic        ref_due;
    logic [7:0]  ref_row;
    logic [7:0]  open_row;
    logic        row_open;
    dram_ctrl_pkg::req_type cur;
    logic [3:0]  din_s1;
    logic [3:0]  din_s2;
    logic        pending;

    function automatic logic [7:0] row_of(input logic [13:0] a);
        row_of = a[`ROW_MSB:`ROW_LSB];
    endfunction : row_of

    // Data lines come from another timing domain
    always_ff @(posedge clk)
    begin
        din_s1 <= data_lines_in;
        din_s2 <= din_s1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b || state == st_ref_low)
        begin
            ref_timer <= 24'h0;
            ref_due   <= (state == st_ref_low) ? 1'b0 : 1'b0;
        end
        else if (ref_timer >= 24'(REFRESH_CYCLES - 1))
        begin
            ref_timer <= 24'h0;
            ref_due   <= 1'b1;
        end
        else
            ref_timer <= ref_timer + 24'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state           <= st_power;
            count           <= 16'h0;
            init_left       <= 4'h0;
            ref_row         <= 8'h0;
            open_row        <= 8'h0;
            row_open        <= 1'b0;
            pending         <= 1'b0;
            cur             <= '0;
            req_ready       <= 1'b0;
            rdata_valid     <= 1'b0;
            rdata           <= 4'h0;
            init_done       <= 1'b0;
            pins            <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                 oe_n: 1'b1, addr: 8'h0};
            data_lines_out  <= 4'h0;
            data_lines_oe_b <= 1'b1;
        end
        else
        begin
            rdata_valid <= 1'b0;
            if (count != 16'h0)
                count <= count - 16'h1;
            case (state)
                // hold row strobe high after power-up
                st_power:
                    if (count == 16'h0)
                    begin
                        if (init_left == 4'h0 && !init_done)
                        begin
                            count     <= 16'(POWERUP_CYCLES);
                            init_left <= 4'(`INIT_CYCLE_COUNT);
                            init_done <= 1'b1;
                        end
                        else
                        begin
                            init_done  <= 1'b0;
                            pins.ras_n <= 1'b0;
                            count      <= 16'(`ROW_ACCESS_CYCLES);
                            state      <= st_init_low;
                        end
                    end
                st_init_low:
                    if (count == 16'h0)
                    begin
                        pins.ras_n <= 1'b1;
                        init_left  <= init_left - 4'h1;
                        count      <= 16'(`PRECHARGE_CYCLES);
                        state      <= st_init_high;
                    end
                st_init_high:
                    if (count == 16'h0)
                    begin
                        if (init_left == 4'h0)
                        begin
                            init_done <= 1'b1;
                            req_ready <= 1'b1;
                            state     <= st_idle;
                        end
                        else
                        begin
                            pins.ras_n <= 1'b0;
                            count      <= 16'(`ROW_ACCESS_CYCLES);
                            state      <= st_init_low;
                        end
                    end
                st_idle:
                    // A request seen with ready high is taken first
                    if (ref_due && !req_valid)
                    begin
                        req_ready <= 1'b0;
                        if (row_open)
                        begin
                            pins.ras_n <= 1'b1;
                            row_open   <= 1'b0;
                            count      <= 16'(`PRECHARGE_CYCLES);
                            state      <= st_precharge;
                        end
                        else
                        begin
                            pins.addr  <= ref_row;
                            pins.ras_n <= 1'b0;
                            count      <= 16'(`ROW_ACCESS_CYCLES);
                            state      <= st_ref_low;
                        end
                    end
                    else if (req_valid)
                    begin
                        req_ready <= 1'b0;
                        cur       <= req;
                        // reuse open row for same page
                        if (row_open && open_row == row_of(req.addr))
                        begin
                            state <= st_row;
                        end
                        else if (row_open)
                        begin
                            pins.ras_n <= 1'b1;
                            row_open   <= 1'b0;
                            count      <= 16'(`PRECHARGE_CYCLES);
                            state      <= st_precharge;
                            req_ready  <= 1'b0;
                            pending    <= 1'b1;
                        end
                        else
                        begin
                            pins.addr <= row_of(req.addr);
                            state     <= st_row;
                        end
                    end
                st_row:
                begin
                    // open row, hold row address, then column
                    if (!row_open)
                    begin
                        pins.ras_n <= 1'b0;
                        row_open   <= 1'b1;
                        open_row   <= row_of(cur.addr);
                        count      <= 16'(`ROW_ACCESS_CYCLES
                                          - `COL_ACCESS_CYCLES);
                    end
                    else if (count == 16'h0)
                    begin
                    // column on lines one to six
                    pins.addr <= {1'b0, cur.addr[`COL_MSB:`COL_LSB], 1'b0};
                    // early write drives data, output stays off
                    if (cur.op == dram_ctrl_pkg::op_write)
                    begin
                        pins.we_n       <= 1'b0;
                        data_lines_out  <= cur.wdata;
                        data_lines_oe_b <= 1'b0;
                    end
                    else
                        pins.oe_n <= 1'b0;
                    count <= 16'(`ROW_ACCESS_CYCLES);
                    state <= st_col;
                    end
                end
                st_col:
                begin
                    pins.cas_n <= 1'b0;
                    // Two extra cycles cover the input synchroniser
                    count      <= 16'(`COL_ACCESS_CYCLES + 2);
                    state      <= (cur.op == dram_ctrl_pkg::op_write)
                                  ? st_col_end : st_read_wait;
                end
                // wait for access, sample while enabled
                st_read_wait:
                    if (count == 16'h0)
                    begin
                        rdata       <= din_s2;
                        rdata_valid <= 1'b1;
                        if (cur.op == dram_ctrl_pkg::op_rmw)
                        begin
                            pins.oe_n <= 1'b1;
                            count     <= 16'(`DISABLE_CYCLES);
                            state     <= st_rmw_float;
                        end
                        else
                            state <= st_col_end;
                    end
                st_rmw_float:
                    if (count == 16'h0)
                    begin
                        data_lines_out  <= cur.wdata;
                        data_lines_oe_b <= 1'b0;
                        state           <= st_rmw_write;
                    end
                st_rmw_write:
                begin
                    pins.we_n <= 1'b0;
                    count     <= 16'(`COL_ACCESS_CYCLES);
                    state     <= st_col_end;
                end
                st_col_end:
                    if (count == 16'h0)
                    begin
                        pins.cas_n      <= 1'b1;
                        pins.we_n       <= 1'b1;
                        pins.oe_n       <= 1'b1;
                        data_lines_oe_b <= 1'b1;
                        if (cur.keep_page)
                        begin
                            req_ready <= 1'b1;
                            state     <= st_idle;
                        end
                        else
                        begin
                            pins.ras_n <= 1'b1;
                            row_open   <= 1'b0;
                            count      <= 16'(`PRECHARGE_CYCLES);
                            state      <= st_precharge;
                        end
                    end
                st_ref_low:
                    if (count == 16'h0)
                    begin
                        pins.ras_n <= 1'b1;
                        ref_row    <= ref_row + 8'h1;
                        count      <= 16'(`PRECHARGE_CYCLES);
                        state      <= st_precharge;
                    end
                st_precharge:
                    if (count == 16'h0 && pending)
                    begin
                        // Page miss: open the new row for the held request
                        pending   <= 1'b0;
                        pins.addr <= row_of(cur.addr);
                        state     <= st_row;
                    end
                    else if (count == 16'h0)
                    begin
                        req_ready <= 1'b1;
                        state     <= st_idle;
                    end
                default:
                    state <= st_idle;
            endcase
        end
    end
endmodule : dram_ctrl

// ---- rtl/dram_ctrl_params.svh ----
// Timing and geometry constants for the dynamic memory controller
`ifndef DRAM_CTRL_PARAMS_SVH
`define DRAM_CTRL_PARAMS_SVH
`define CLK_PERIOD_NS        10
`define POWERUP_HOLD_US      100
`define POWERUP_HOLD_CYCLES  ((`POWERUP_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define INIT_CYCLE_COUNT     8
`define REFRESH_PERIOD_MS    4
`define ROW_COUNT            256
`define REFRESH_INT_CYCLES   ((`REFRESH_PERIOD_MS * 1000000) / `CLK_PERIOD_NS / `ROW_COUNT)
`define ROW_ACCESS_NS        120
`define ROW_ACCESS_CYCLES    ((`ROW_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_ACCESS_NS        70
`define COL_ACCESS_CYCLES    ((`COL_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_NS         120
`define PRECHARGE_CYCLES     ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DISABLE_NS           30
`define DISABLE_CYCLES       ((`DISABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_MSB              13
`define ROW_LSB              6
`define COL_MSB              5
`define COL_LSB              0
`endif

// ---- rtl/dram_ctrl_pkg.sv ----
// Types for the dynamic memory controller
package dram_ctrl_pkg;
    typedef enum logic [1:0] {
        op_read,
        op_write,
        op_rmw
    } op_type;

    typedef struct packed {
        op_type      op;
        logic [13:0] addr;
        logic [3:0]  wdata;
        logic        keep_page;
    } req_type;

    typedef struct packed {
        logic       ras_n;
        logic       cas_n;
        logic       we_n;
        logic       oe_n;
        logic [7:0] addr;
    } pins_type;
endpackage : dram_ctrl_pkg

// ---- testbench/dram_ctrl_assertions.sv ----
// Concurrent checks on the memory controller ports
`timescale 1ns/100ps
module dram_ctrl_assertions #(
    parameter int POWERUP_CYCLES = 10000,
    parameter int REFRESH_CYCLES = 1562
) (
    input wire logic                    clk,
    input wire logic                    rst_b,
    input wire logic                    req_ready,
    input wire logic                    rdata_valid,
    input wire dram_ctrl_pkg::pins_type pins,
    input wire logic [3:0]              data_lines_out,
    input wire logic                    data_lines_oe_b
);
    int unsigned hold;
    int unsigned falls;
    int unsigned gap;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hold <= 0;
            falls <= 0;
            gap <= 0;
        end
        else
        begin
            if (pins.ras_n && falls == 0)
                hold <= hold + 1;
            if ($fell(pins.ras_n) && falls < 8)
                falls <= falls + 1;
            gap <= $fell(pins.ras_n) ? 0 : gap + 1;
        end
    end
    property p_hold;
        $fell(pins.ras_n) && falls == 0 |-> hold >= POWERUP_CYCLES - 1;
    endproperty
    a_hold: assert property (p_hold) else $error("short power hold");
    property p_init; $rose(req_ready) |-> falls == 8; endproperty
    a_init: assert property (p_init) else $error("init cycles short");
    property p_gap; falls == 8 |-> gap <= REFRESH_CYCLES + 64; endproperty
    a_gap: assert property (p_gap) else $error("refresh late");
    property p_addr; $fell(pins.cas_n) |-> $stable(pins.addr); endproperty
    a_addr: assert property (p_addr) else $error("address moved");
    property p_page; !pins.cas_n |-> !pins.ras_n; endproperty
    a_page: assert property (p_page) else $error("column without row");
    property p_float;
        $fell(data_lines_oe_b) && !pins.cas_n |-> pins.oe_n && $past(pins.oe_n);
    endproperty
    a_float: assert property (p_float) else $error("drove into output");
    property p_late;
        $fell(pins.we_n) && !pins.cas_n |-> !data_lines_oe_b && pins.oe_n;
    endproperty
    a_late: assert property (p_late) else $error("late write no data");
    property p_early;
        $fell(pins.cas_n) && !pins.we_n |->
            !data_lines_oe_b && $stable(data_lines_out);
    endproperty
    a_early: assert property (p_early) else $error("early write data");
    c_read: cover property (rdata_valid);
    c_rmw: cover property ($fell(pins.we_n) && !pins.cas_n);
    c_refresh: cover property ($fell(pins.ras_n) && falls == 8);
endmodule : dram_ctrl_assertions
bind dram_ctrl dram_ctrl_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES),
    .REFRESH_CYCLES(REFRESH_CYCLES)) i_dram_ctrl_assertions (.clk(clk),
    .rst_b(rst_b), .req_ready(req_ready), .rdata_valid(rdata_valid),
    .pins(pins), .data_lines_out(data_lines_out),
    .data_lines_oe_b(data_lines_oe_b));

// ---- testbench/dram_ctrl_tb.sv ----
// Self-checking bench for the dynamic memory controller
`timescale 1ns/100ps
module dram_ctrl_tb;
    logic                    clk = 1'b0;
    logic                    rst_b = 1'b0;
    logic                    req_valid = 1'b0;
    dram_ctrl_pkg::req_type  req = '0;
    logic                    req_ready;
    logic                    rdata_valid;
    logic [3:0]              rdata;
    dram_ctrl_pkg::pins_type pins;
    logic [3:0]              dq;
    logic [3:0]              ctrl_out;
    logic                    ctrl_oe_b;
    logic [3:0]              mem_q;
    logic                    mem_en;
    logic [3:0]              got;
    logic                    init_done;
    int                      bad_count = 0;
    int                      checks = 0;
    always #5 clk = ~clk;
    // Released lines show the inverse of the last value, not a lucky match
    assign dq = !ctrl_oe_b ? ctrl_out : mem_en ? mem_q : ~mem_q;
    dram_ctrl #(.POWERUP_CYCLES(20), .REFRESH_CYCLES(400)) i_dram_ctrl (
        .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rdata_valid(rdata_valid), .rdata(rdata),
        .init_done(init_done), .pins(pins), .data_lines_in(dq),
        .data_lines_out(ctrl_out), .data_lines_oe_b(ctrl_oe_b));
    dram_device_model #(.ACCESS_NS(60)) i_dram_device_model (
        .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .oe_n(pins.oe_n), .addr(pins.addr), .dq_in(dq), .q(mem_q),
        .en(mem_en));
    task automatic finish_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait on ready (0) or read data valid (1)
    task automatic wait_for(input bit which);
        int n;
        n = 0;
        while ((which ? rdata_valid : req_ready) !== 1'b1)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > 3000)
            begin
                check(4'h0, 4'h1);
                finish_test();
            end
        end
    endtask : wait_for
    task automatic access(input dram_ctrl_pkg::op_type op,
                          input logic [13:0] a, input logic [3:0] d,
                          input logic kp);
        @(posedge clk);
        #1;
        req = '{op, a, d, kp};
        req_valid = 1'b1;
        wait_for(1'b0);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        if (op != dram_ctrl_pkg::op_write)
        begin
            wait_for(1'b1);
            got = rdata;
        end
    endtask : access
    // Memory and controller never drive the lines together
    always @(negedge clk)
        if (mem_en === 1'b1)
            check(4'(ctrl_oe_b), 4'h1);
    task automatic sc_init();
        check(4'(pins.ras_n), 4'h1);
        check(4'(req_ready), 4'h0);
        wait_for(1'b0);
        check(4'(pins.cas_n), 4'h1);
        check(4'(init_done), 4'h1);
    endtask : sc_init
    task automatic sc_rw();
        logic [13:0] a [4] = '{14'h0000, 14'h3fff, 14'h2a41, 14'h0041};
        for (int i = 0; i < 4; i++)
            access(dram_ctrl_pkg::op_write, a[i], 4'(i * 5 + 3), 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            access(dram_ctrl_pkg::op_read, a[i], 4'h0, 1'b0);
            check(got, 4'(i * 5 + 3));
        end
    endtask : sc_rw
    task automatic sc_page();
        access(dram_ctrl_pkg::op_write, 14'h1680, 4'h6, 1'b1);
        access(dram_ctrl_pkg::op_write, 14'h16bf, 4'h9, 1'b1);
        access(dram_ctrl_pkg::op_read, 14'h1680, 4'h0, 1'b1);
        check(got, 4'h6);
        wait_for(1'b0);
        check(4'(pins.ras_n), 4'h0);
        access(dram_ctrl_pkg::op_read, 14'h16bf, 4'h0, 1'b0);
        check(got, 4'h9);
    endtask : sc_page
    task automatic sc_rmw();
        access(dram_ctrl_pkg::op_write, 14'h3c0f, 4'h7, 1'b0);
        access(dram_ctrl_pkg::op_rmw, 14'h3c0f, 4'h2, 1'b0);
        check(got, 4'h7);
        access(dram_ctrl_pkg::op_read, 14'h3c0f, 4'h0, 1'b0);
        check(got, 4'h2);
    endtask : sc_rmw
    task automatic sc_refresh();
        int falls;
        logic last;
        falls = 0;
        last = pins.ras_n;
        repeat (900)
        begin
            @(posedge clk);
            #1;
            falls += int'(last && !pins.ras_n && pins.cas_n);
            last = pins.ras_n;
        end
        check(4'(falls >= 2), 4'h1);
        access(dram_ctrl_pkg::op_read, 14'h3fff, 4'h0, 1'b0);
        check(got, 4'h8);
    endtask : sc_refresh
    initial
    begin
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        sc_init();
        sc_rw();
        sc_page();
        sc_rmw();
        sc_refresh();
        finish_test();
    end
endmodule : dram_ctrl_tb

// ---- testbench/dram_device_model.sv ----
// Behavioural 16K by 4 dynamic memory on the controller's pins
`timescale 1ns/100ps
module dram_device_model #(
    parameter int ACCESS_NS = 30
) (
    // Strobes and address
    input  wire logic       ras_n,
    input  wire logic       cas_n,
    input  wire logic       we_n,
    input  wire logic       oe_n,
    input  wire logic [7:0] addr,
    // Data lines
    input  wire logic [3:0] dq_in,
    output logic [3:0]      q,
    output logic            en
);
    logic [3:0] mem [16384];
    logic [7:0] row;
    logic [5:0] col;
    logic       early = 1'b0;
    int         inits = 0;
    // row latched and refreshed; writes lost before init
    always @(negedge ras_n)
    begin
        row = addr;
        if (inits < 8)
            inits++;
    end
    // column latched, early write data taken
    always @(negedge cas_n)
    begin
        col = addr[6:1];
        early = !we_n;
        if (early && inits == 8)
            mem[{row, col}] = dq_in;
        q <= #(ACCESS_NS) mem[{row, col}];
    end
    // delayed write data taken on write select fall
    always @(negedge we_n)
        if (!cas_n && !ras_n && inits == 8)
            mem[{row, col}] = dq_in;
    // unlatched output, driven only with row, column and output strobes low and no early write
    assign en = !ras_n && !cas_n && !oe_n && !early;
endmodule : dram_device_model
